// ---- rtl/pia_arbiter.sv ----
// Purpose: priority interrupt arbiter facing the processor core
// Assumes: all inputs synchronous to i_clock; core holds the mask word
// Notes:   sources are held pending until the core accepts them
`timescale 1ns/100ps
`default_nettype none
`include "pia_params.svh"

module pia_arbiter
    import pia_pkg::*;
(
    // clock and reset
    input  wire logic                                  i_clock,
    input  wire logic                                  i_reset_n,
    // cpu-generated events (one-cycle pulses)
    input  wire logic [`PIA_NUM_SWI-1:0]               i_sw_req,
    input  wire logic                                  i_illegal_instr,
    // internal events (one-cycle pulses)
    input  wire logic                                  i_watchdog,
    input  wire logic [`PIA_NUM_PERIPH-1:0]            i_periph_req,
    // external pins (levels, rising edge requests)
    input  wire logic                                  i_nmi_pin,
    input  wire logic [`PIA_NUM_EXT-1:0]               i_external_request_pin,
    input  wire logic                                  i_key_wakeup_request,
    // per maskable source setup
    input  wire logic [`PIA_NUM_MASKABLE-1:0][2:0]     i_level_cfg,
    input  wire logic [`PIA_NUM_MASKABLE-1:0]          i_xfer_sel,
    input  wire logic [`PIA_NUM_MASKABLE-1:0][1:0]     i_xfer_size,
    // software start of an auto-transfer
    input  wire logic                                  i_sw_xfer_start,
    input  wire logic [5:0]                            i_sw_xfer_slot,
    // processor core side
    input  wire logic [2:0]                            i_interrupt_mask_level,
    input  wire logic                                  i_accept,
    // offer to the core
    output logic                                       o_req_valid,
    output logic [2:0]                                 o_req_level,
    output logic [5:0]                                 o_req_slot,
    output logic                                       o_irq,
    // acceptance results
    output logic                                       o_handler_start,
    output logic [2:0]                                 o_accept_mask,
    output logic                                       o_xfer_start,
    output logic [5:0]                                 o_xfer_slot,
    output logic [1:0]                                 o_xfer_size,
    // pending view
    output logic [`PIA_NUM_SLOTS-1:0]                  o_pending
);

    // ----------------------------------------
    // pin edge detection
    // ----------------------------------------
    logic                          nmi_q;
    logic [`PIA_NUM_EXT-1:0]       ext_q;
    logic                          key_q;
    logic                          next_nmi_q;
    logic [`PIA_NUM_EXT-1:0]       next_ext_q;
    logic                          next_key_q;

    always_comb begin
        next_nmi_q = i_nmi_pin;
        next_ext_q = i_external_request_pin;
        next_key_q = i_key_wakeup_request;
    end

    // pins idle low after reset so a pin already high requests once
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            nmi_q <= 1'b0;
            ext_q <= '0;
            key_q <= 1'b0;
        end else begin
            nmi_q <= next_nmi_q;
            ext_q <= next_ext_q;
            key_q <= next_key_q;
        end
    end

    // ----------------------------------------
    // source to slot map
    // ----------------------------------------
    logic [`PIA_NUM_SLOTS-1:0]     raw_event;

    genvar g;
    generate
        for (g = 0; g < `PIA_NUM_SLOTS; g++) begin : g_map
            if (g == `PIA_SLOT_ILLEGAL) begin : g_ill
                // illegal instruction shares the third software vector
                assign raw_event[g] = i_sw_req[g] | i_illegal_instr;
            end else if (g < `PIA_NUM_SWI) begin : g_swi
                assign raw_event[g] = i_sw_req[g];
            end else if (g == `PIA_SLOT_NMI) begin : g_nmi
                assign raw_event[g] = i_nmi_pin & ~nmi_q;
            end else if (g == `PIA_SLOT_WDOG) begin : g_wd
                assign raw_event[g] = i_watchdog;
            end else if (g < `PIA_SLOT_PER_LO) begin : g_ext
                assign raw_event[g] = i_external_request_pin[g-`PIA_SLOT_EXT_A]
                                    & ~ext_q[g-`PIA_SLOT_EXT_A];
            end else if (g < `PIA_SLOT_KEY) begin : g_plo
                assign raw_event[g] = i_periph_req[g-`PIA_SLOT_PER_LO];
            end else if (g == `PIA_SLOT_KEY) begin : g_key
                assign raw_event[g] = i_key_wakeup_request & ~key_q;
            end else begin : g_phi
                assign raw_event[g] =
                    i_periph_req[g-`PIA_SLOT_PER_HI+`PIA_PER_SPLIT];
            end
        end
    endgenerate

    // ----------------------------------------
    // software auto-transfer start
    // ----------------------------------------
    logic [`PIA_NUM_SLOTS-1:0]     sw_xfer_event;

    always_comb begin
        sw_xfer_event = '0;
        // only maskable slots carry an auto-transfer setup
        if (i_sw_xfer_start && (i_sw_xfer_slot >= 6'(`PIA_NUM_NONMASK))
            && (i_sw_xfer_slot < 6'(`PIA_NUM_SLOTS))) begin
            sw_xfer_event[i_sw_xfer_slot] = 1'b1;
        end
    end

    // ----------------------------------------
    // pending flags
    // ----------------------------------------
    logic [`PIA_NUM_SLOTS-1:0]     pending;
    logic [`PIA_NUM_SLOTS-1:0]     next_pending;
    logic                          take;
    pia_state_e                    state;
    pia_state_e                    next_state;

    assign take = i_accept && (state == PIA_ST_OFFER);

    always_comb begin
        next_pending = pending;
        // only the accepted slot clears, others stay held
        if (take) begin
            next_pending[o_req_slot] = 1'b0;
        end
        // a new event in the accept cycle is kept
        next_pending = next_pending | raw_event | sw_xfer_event;
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // ----------------------------------------
    // priority pick
    // ----------------------------------------
    pia_offer_s                    pick;

    pia_prio_pick u_pick (
        .i_pending   (pending),
        .i_level_cfg (i_level_cfg),
        .o_offer     (pick)
    );

    // ----------------------------------------
    // offer state machine
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            PIA_ST_IDLE: begin
                if (pick.valid) begin
                    next_state = PIA_ST_OFFER;
                end
            end
            PIA_ST_OFFER: begin
                // two quiet cycles (SETTLE, then IDLE) let the cleared flag leave the pick
                if (take) begin
                    next_state = PIA_ST_SETTLE;
                end else if (!pick.valid) begin
                    next_state = PIA_ST_IDLE;
                end
            end
            PIA_ST_SETTLE: begin
                next_state = PIA_ST_IDLE;
            end
            default: begin
                next_state = PIA_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state <= PIA_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // offer registers
    // ----------------------------------------
    pia_offer_s                    offer;
    pia_offer_s                    next_offer;
    logic                          next_irq;

    always_comb begin
        next_offer = '0;
        if (next_state == PIA_ST_OFFER) begin
            next_offer = pick;
        end
        // mask is read every cycle, so a fresh mask reaches o_irq at the next edge
        next_irq = next_offer.valid
                 && (next_offer.level > i_interrupt_mask_level);
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            offer <= '0;
            o_irq <= 1'b0;
        end else begin
            offer <= next_offer;
            o_irq <= next_irq;
        end
    end

    assign o_req_valid = offer.valid;
    assign o_req_level = offer.level;
    assign o_req_slot  = offer.slot;
    assign o_pending   = pending;

    // ----------------------------------------
    // acceptance results
    // ----------------------------------------
    pia_xfer_s                     xfer;
    pia_xfer_s                     next_xfer;
    logic                          handler;
    logic                          next_handler;
    pia_level_t                    amask;
    pia_level_t                    next_amask;
    logic                          use_xfer;
    logic [4:0]                    midx;

    always_comb begin
        midx     = 5'(offer.slot - 6'(`PIA_NUM_NONMASK));
        use_xfer = (offer.slot >= 6'(`PIA_NUM_NONMASK)) && i_xfer_sel[midx];
        next_xfer    = '0;
        next_handler = 1'b0;
        next_amask   = amask;
        if (take) begin
            if (use_xfer) begin
                // auto-transfer replaces the handler
                next_xfer.start = 1'b1;
                next_xfer.slot  = offer.slot;
                next_xfer.size  = (i_xfer_size[midx] > `PIA_SIZE_4B)
                                ? `PIA_SIZE_4B : i_xfer_size[midx];
            end else begin
                next_handler = 1'b1;
            end
            // level seven leaves the mask at seven
            next_amask = (offer.level == `PIA_LVL_TOP)
                       ? `PIA_LVL_TOP : offer.level + `PIA_LVL_ONE;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            xfer    <= '0;
            handler <= 1'b0;
            amask   <= `PIA_LVL_TOP;
        end else begin
            xfer    <= next_xfer;
            handler <= next_handler;
            amask   <= next_amask;
        end
    end

    assign o_xfer_start    = xfer.start;
    assign o_xfer_slot     = xfer.slot;
    assign o_xfer_size     = xfer.size;
    assign o_handler_start = handler;
    assign o_accept_mask   = amask;

endmodule : pia_arbiter
`default_nettype wire

// ---- rtl/pia_params.svh ----
// Purpose: constants of the priority interrupt arbiter
// Assumes: included by its bare name
// Notes:   slot = vector value / 4
`ifndef PIA_PARAMS_SVH
`define PIA_PARAMS_SVH

// ----------------------------------------
// source counts
// ----------------------------------------
`define PIA_NUM_SOURCES   39
`define PIA_NUM_SLOTS     38
`define PIA_NUM_NONMASK   10
`define PIA_NUM_MASKABLE  28
`define PIA_NUM_SWI       8
`define PIA_NUM_EXT       4
`define PIA_NUM_PERIPH    23

// ----------------------------------------
// fixed slot positions
// ----------------------------------------
`define PIA_SLOT_ILLEGAL  2
`define PIA_SLOT_NMI      8
`define PIA_SLOT_WDOG     9
`define PIA_SLOT_EXT_A    10
`define PIA_SLOT_PER_LO   14
`define PIA_SLOT_KEY      28
`define PIA_SLOT_PER_HI   29
`define PIA_PER_SPLIT     14

// ----------------------------------------
// levels and encodings
// ----------------------------------------
`define PIA_LVL_TOP       3'h7
`define PIA_LVL_OFF       3'h0
`define PIA_LVL_ONE       3'h1
`define PIA_SIZE_1B       2'h0
`define PIA_SIZE_2B       2'h1
`define PIA_SIZE_4B       2'h2
`define PIA_VEC_SHIFT     2

`endif

// ---- rtl/pia_pkg.sv ----
// Purpose: types of the priority interrupt arbiter
// Assumes: pia_params.svh holds the numbers
// Notes:   none
package pia_pkg;

typedef logic [2:0] pia_level_t;
typedef logic [5:0] pia_slot_t;
typedef logic [1:0] pia_size_t;

typedef enum logic [1:0] {
    PIA_ST_IDLE   = 2'h0,
    PIA_ST_OFFER  = 2'h1,
    PIA_ST_SETTLE = 2'h3
} pia_state_e;

typedef struct packed {
    logic       valid;
    pia_level_t level;
    pia_slot_t  slot;
} pia_offer_s;

typedef struct packed {
    logic      start;
    pia_slot_t slot;
    pia_size_t size;
} pia_xfer_s;

endpackage : pia_pkg

// ---- rtl/pia_prio_pick.sv ----
// Purpose: pick the highest pending level, smallest slot on a tie
// Assumes: purely combinational, read by the arbiter's flops
// Notes:   maskable levels 0 and 7 count as disabled
`timescale 1ns/100ps
`default_nettype none
`include "pia_params.svh"

module pia_prio_pick
    import pia_pkg::*;
(
    // pending sources and their levels
    input  wire logic [`PIA_NUM_SLOTS-1:0]             i_pending,
    input  wire logic [`PIA_NUM_MASKABLE-1:0][2:0]     i_level_cfg,
    // winner
    output var pia_offer_s                             o_offer
);

    pia_level_t eff [`PIA_NUM_SLOTS];

    genvar g;
    generate
        for (g = 0; g < `PIA_NUM_SLOTS; g++) begin : g_lvl
            if (g < `PIA_NUM_NONMASK) begin : g_nm
                assign eff[g] = `PIA_LVL_TOP;
            end else begin : g_m
                assign eff[g] = (i_level_cfg[g-`PIA_NUM_NONMASK] == `PIA_LVL_TOP)
                              ? `PIA_LVL_OFF : i_level_cfg[g-`PIA_NUM_NONMASK];
            end
        end
    endgenerate

    always_comb begin
        o_offer = '0;
        // walk downward so an equal level at a smaller slot wins
        for (int i = `PIA_NUM_SLOTS - 1; i >= 0; i--) begin
            if (i_pending[i] && (eff[i] != `PIA_LVL_OFF)
                && (eff[i] >= o_offer.level)) begin
                o_offer.valid = 1'b1;
                o_offer.level = eff[i];
                o_offer.slot  = pia_slot_t'(i);
            end
        end
    end

endmodule : pia_prio_pick
`default_nettype wire

// ---- verif/pia_arbiter_checker.sv ----
// Purpose: concurrent checks on the arbiter's core-facing ports
// Assumes: bound to pia_arbiter, one clock domain
// Notes:   start pulses are judged against the accept seen one edge before
`timescale 1ns/100ps
`default_nettype none
`include "pia_params.svh"

module pia_arbiter_checker (
    input wire logic                      i_clock,
    input wire logic                      i_reset_n,
    input wire logic [2:0]                i_interrupt_mask_level,
    input wire logic                      i_accept,
    input wire logic                      o_req_valid,
    input wire logic [2:0]                o_req_level,
    input wire logic [5:0]                o_req_slot,
    input wire logic                      o_irq,
    input wire logic                      o_handler_start,
    input wire logic [2:0]                o_accept_mask,
    input wire logic                      o_xfer_start,
    input wire logic [5:0]                o_xfer_slot,
    input wire logic [1:0]                o_xfer_size,
    input wire logic [`PIA_NUM_SLOTS-1:0] o_pending
);
default clocking cb @(posedge i_clock);
endclocking
default disable iff (!i_reset_n);

// ----
// helper state
// ----
logic       taken_q;
logic [5:0] slot_q;
always_ff @(posedge i_clock) begin
    taken_q <= i_reset_n & i_accept & o_req_valid;
    slot_q  <= o_req_slot;
end

sequence s_taken;
    i_accept && o_req_valid;
endsequence
sequence s_settle;
    !o_req_valid ##1 !o_req_valid;
endsequence

// ----
// assertions
// ----
a_reset_out: assert property (disable iff (1'b0)
    !i_reset_n |=> o_accept_mask == 3'h7 && !o_req_valid && !o_irq)
    else $error("outputs wrong after reset");
a_accept_mask: assert property (
    s_taken |=> o_accept_mask == (($past(o_req_level) == 3'h7) ? 3'h7 : $past(o_req_level) + 3'h1))
    else $error("accept mask not level plus one");
a_settle_gap: assert property (
    s_taken |=> s_settle)
    else $error("offer not withdrawn after accept");
a_irq_gate: assert property (
    o_irq == (o_req_valid && o_req_level > $past(i_interrupt_mask_level)))
    else $error("irq does not match level against mask");
a_nm_level: assert property (
    o_req_valid && o_req_slot < 6'h0A |-> o_req_level == 3'h7)
    else $error("non-maskable slot offered below top level");
a_off_levels: assert property (
    o_req_valid && o_req_slot >= 6'h0A |-> o_req_level inside {[3'h1:3'h6]})
    else $error("disabled maskable level offered");
a_start_cause: assert property (
    o_handler_start || o_xfer_start |-> taken_q && !(o_handler_start && o_xfer_start))
    else $error("start pulse without single accept");
a_xfer_slot: assert property (
    o_xfer_start |-> o_xfer_slot == slot_q && o_xfer_size != 2'h3)
    else $error("transfer slot or size wrong");
a_pend_hold: assert property (
    |($past(o_pending) & ~o_pending) |-> taken_q)
    else $error("pending flag dropped without accept");
endmodule : pia_arbiter_checker

bind pia_arbiter pia_arbiter_checker chk_u (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_interrupt_mask_level(i_interrupt_mask_level), .i_accept(i_accept),
    .o_req_valid(o_req_valid), .o_req_level(o_req_level), .o_req_slot(o_req_slot),
    .o_irq(o_irq), .o_handler_start(o_handler_start), .o_accept_mask(o_accept_mask),
    .o_xfer_start(o_xfer_start), .o_xfer_slot(o_xfer_slot), .o_xfer_size(o_xfer_size),
    .o_pending(o_pending));
`default_nettype wire

// ---- verif/pia_core_model.sv ----
// Purpose: processor core that takes vectored offers and keeps the mask
// Assumes: offer outputs of the arbiter are registered
// Notes:   no return from service; the bench lowers the mask itself
`timescale 1ns/100ps
`default_nettype none

module pia_core_model (
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    input  wire logic       i_req_valid,
    input  wire logic [2:0] i_req_level,
    input  wire logic       i_irq,
    input  wire logic [2:0] i_accept_mask,
    input  wire logic       i_mask_set,
    input  wire logic [2:0] i_mask_value,
    input  wire logic       i_stall,
    output logic            o_accept,
    output logic [2:0]      o_mask
);
logic took_q;
// top level cannot be masked, so it bypasses the irq compare
assign o_accept = i_req_valid && !i_stall && (i_irq || i_req_level == 3'h7);
always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
        o_mask <= 3'h7;
        took_q <= 1'b0;
    end else begin
        took_q <= o_accept;
        if (i_mask_set) begin
            o_mask <= i_mask_value;
        end else if (took_q) begin
            o_mask <= i_accept_mask;
        end
    end
end
endmodule : pia_core_model
`default_nettype wire

// ---- verif/priority_interrupt_arbiter_bench.sv ----
// Purpose: directed scenarios for the interrupt arbiter with a core model
// Assumes: inputs change by non-blocking assignment at rising edges
// Notes:   each scenario judges its own results before it returns
`timescale 1ns/100ps
`default_nettype none

module priority_interrupt_arbiter_bench;
logic clock = 0, reset_n = 0, wd = 0, nmi = 0, sws = 0, mset = 0, stall = 0, ill = 0, key = 0;
logic [7:0] swr = '0;
logic [3:0] ext = '0;
logic [22:0] per = '0;
logic [27:0][2:0] lvl = '0;
logic [27:0] xsel = '0;
logic [27:0][1:0] xsz = '0;
logic [5:0] sws_slot = '0, req_slot, xslot, s;
logic [2:0] mval = '0, req_level, acc_mask, mask;
logic [1:0] xsize, sz;
logic req_valid, irq, hs, xs, accept, x;
logic [37:0] pend;
int n_fail = 0, comparisons = 0;
always #20 clock = ~clock;

pia_arbiter dut_u (.i_clock(clock), .i_reset_n(reset_n), .i_sw_req(swr),
    .i_illegal_instr(ill), .i_watchdog(wd), .i_periph_req(per), .i_nmi_pin(nmi),
    .i_external_request_pin(ext), .i_key_wakeup_request(key), .i_level_cfg(lvl),
    .i_xfer_sel(xsel), .i_xfer_size(xsz), .i_sw_xfer_start(sws), .i_sw_xfer_slot(sws_slot),
    .i_interrupt_mask_level(mask), .i_accept(accept), .o_req_valid(req_valid),
    .o_req_level(req_level), .o_req_slot(req_slot), .o_irq(irq), .o_handler_start(hs),
    .o_accept_mask(acc_mask), .o_xfer_start(xs), .o_xfer_slot(xslot), .o_xfer_size(xsize),
    .o_pending(pend));
pia_core_model core_u (.i_clock(clock), .i_reset_n(reset_n), .i_req_valid(req_valid),
    .i_req_level(req_level), .i_irq(irq), .i_accept_mask(acc_mask), .i_mask_set(mset),
    .i_mask_value(mval), .i_stall(stall), .o_accept(accept), .o_mask(mask));

// ----
// shared tasks
// ----
task automatic chk(input string what, input logic [37:0] exp, input logic [37:0] got);
    comparisons++;
    if (got !== exp) begin
        n_fail++;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
endtask : chk
task automatic set_mask(input logic [2:0] v);
    @(posedge clock);
    mset <= 1'b1;
    mval <= v;
    @(posedge clock);
    mset <= 1'b0;
endtask : set_mask
task automatic wait_start();
    logic [5:0] acc;
    int i;
    acc = 6'h3F;
    s = 6'h3F;
    x = 1'b0;
    sz = 2'h0;
    // step off the edge so an accept raised there is seen before it is taken
    #1;
    for (i = 0; i < 40 && s == 6'h3F; i++) begin
        if (accept) acc = req_slot;
        @(posedge clock);
        #1;
        if (hs || xs) begin
            s = acc;
            x = xs;
            sz = xsize;
        end
    end
endtask : wait_start

// ----
// scenarios
// ----
task automatic t_basic();
    @(posedge clock);
    lvl[4] <= 3'h3;
    per[0] <= 1'b1;
    @(posedge clock);
    per[0] <= 1'b0;
    #1 chk("pend14", 1, pend[14]);
    @(posedge clock);
    #1 chk("offer", {1'b1, 3'h3, 6'd14, 1'b0}, {req_valid, req_level, req_slot, irq});
    repeat (4) @(posedge clock);
    #1 chk("held", 2'b11, {req_valid, pend[14]});
    set_mask(3'h2);
    wait_start();
    chk("basic", {6'd14, 1'b0, 3'h4, 1'b0}, {s, x, acc_mask, pend[14]});
endtask : t_basic
task automatic t_tie();
    @(posedge clock);
    lvl[8:5] <= {3'h7, 3'h0, 3'h4, 3'h4};
    stall <= 1'b1;
    set_mask(3'h0);
    per[4:1] <= 4'hF;
    @(posedge clock);
    per[4:1] <= 4'h0;
    repeat (3) @(posedge clock);
    #1 chk("tie", {1'b1, 6'd15, 1'b1}, {req_valid, req_slot, irq});
    @(posedge clock);
    stall <= 1'b0;
    wait_start();
    chk("first", {6'd15, 3'h5}, {s, acc_mask});
    set_mask(3'h0);
    wait_start();
    chk("second", 6'd16, s);
    repeat (6) @(posedge clock);
    #1 chk("off", 3'b011, {req_valid, pend[18:17]});
endtask : t_tie
task automatic t_nonmask();
    int i;
    logic [5:0] order [3];
    order = '{6'd1, 6'd8, 6'd9};
    @(posedge clock);
    nmi <= 1'b1;
    wd <= 1'b1;
    swr[1] <= 1'b1;
    @(posedge clock);
    wd <= 1'b0;
    swr[1] <= 1'b0;
    for (i = 0; i < 3; i++) begin
        wait_start();
        chk("nonmask", {order[i], 3'h7}, {s, acc_mask});
    end
    @(posedge clock);
    nmi <= 1'b0;
endtask : t_nonmask
task automatic t_xfer();
    int k;
    @(posedge clock);
    {lvl[0], xsel[0], xsz[0]} <= {3'h2, 1'b1, 2'h2};
    set_mask(3'h0);
    ext[0] <= 1'b1;
    wait_start();
    chk("pin xfer", {6'd10, 1'b1, 2'h2}, {s, x, sz});
    @(posedge clock);
    ext[0] <= 1'b0;
    for (k = 0; k < 3; k++) begin
        @(posedge clock);
        {lvl[10], xsel[10], xsz[10]} <= {3'h1, 1'b1, 2'(k)};
        set_mask(3'h0);
        sws <= 1'b1;
        sws_slot <= 6'd20;
        @(posedge clock);
        sws <= 1'b0;
        wait_start();
        chk("sw xfer", {6'd20, 1'b1, 2'(k)}, {s, x, sz});
    end
endtask : t_xfer
task automatic t_mask_all();
    @(posedge clock);
    lvl[9] <= 3'h6;
    set_mask(3'h7);
    per[5] <= 1'b1;
    @(posedge clock);
    per[5] <= 1'b0;
    repeat (6) @(posedge clock);
    #1 chk("blocked", {1'b1, 3'h6, 1'b0, 1'b1}, {req_valid, req_level, irq, pend[19]});
    set_mask(3'h5);
    wait_start();
    chk("unblocked", {6'd19, 3'h7}, {s, acc_mask});
endtask : t_mask_all
task automatic t_pins();
    @(posedge clock);
    lvl[18] <= 3'h3;
    ill <= 1'b1;
    key <= 1'b1;
    @(posedge clock);
    ill <= 1'b0;
    wait_start();
    chk("illegal", {6'd2, 3'h7}, {s, acc_mask});
    set_mask(3'h0);
    wait_start();
    chk("key", {6'd28, 1'b0}, {s, x});
    @(posedge clock);
    key <= 1'b0;
endtask : t_pins

task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask : summarize

initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    summarize();
end

initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1 chk("reset", {3'h7, 1'b0, 1'b0, 1'b0}, {acc_mask, irq, hs, xs});
    chk("reset pend", 38'h0, {pend[37:1], req_valid});
    t_basic();
    t_tie();
    t_nonmask();
    t_xfer();
    t_mask_all();
    t_pins();
    summarize();
end
endmodule : priority_interrupt_arbiter_bench
`default_nettype wire
